// file: pkg/debounced_shutdown_flag_pkg.sv
package debounced_shutdown_flag_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_SLOT = 8'h10;

  localparam int CTRL_LEVEL_BIT = 0;
  localparam int CTRL_IRQ_EN_BIT = 1;
  localparam int CTRL_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

  localparam int COUNT_W = 8;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h04;

  localparam int STAT_DETECT_BIT = 0;
  localparam int STAT_SEQ_DONE_BIT = 1;
  localparam int STAT_W = 2;
  localparam logic [STAT_W-1:0] MASK_RESET = 2'h0;

  localparam int SLOT_ACTIVE_BIT = 0;
  localparam int SLOT_POWERED_BIT = 1;
  localparam int SLOT_FLAG_BIT = 2;
  localparam int SLOT_STAGED_BIT = 3;
  localparam int SLOT_INSTANT_BIT = 4;

  localparam int STAGE_CYCLES = 1;

  typedef enum logic [1:0] {
    SHUT_NONE,
    SHUT_INSTANT,
    SHUT_STAGED
  } shut_kind_type;

  typedef struct packed {
    logic rst_low;
    logic clk_stop;
    logic io_low;
    logic vcc_off;
  } slot_ctrl_type;

endpackage

// file: hdl/sdn_debounce_counter.sv
`timescale 1ns/10ps
`default_nettype none
module sdn_debounce_counter #(
  parameter int COUNT_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_active,
  input wire logic [COUNT_W-1:0] i_load,
  output logic o_expired
);
  logic [COUNT_W-1:0] cnt_q;
  logic [COUNT_W-1:0] cnt_d;
  logic exp_q;
  logic exp_d;

  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (!i_active) begin
      cnt_d = i_load;
    end else if (i_tick) begin
      // A loaded zero counts as one tick so the detector never stalls
      if (cnt_q <= COUNT_W'(1)) begin
        exp_d = 1'b1;
        cnt_d = i_load;
      end else begin
        cnt_d = cnt_q - COUNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign o_expired = exp_q;
endmodule
`default_nettype wire

// file: hdl/shutdown_input_debounce.sv
`timescale 1ns/10ps
`default_nettype none
module shutdown_input_debounce #(
  parameter int COUNT_W = debounced_shutdown_flag_pkg::COUNT_W
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick_32k,
  input wire logic i_shutdown_request_input,
  input wire logic i_host_card_clock_running,
  input wire logic [debounced_shutdown_flag_pkg::ADDR_W-1:0] i_wb_adr,
  input wire logic [debounced_shutdown_flag_pkg::DATA_W-1:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic i_wb_we,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  output logic [debounced_shutdown_flag_pkg::DATA_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_irq,
  output logic o_debounced_shutdown_flag,
  output debounced_shutdown_flag_pkg::slot_ctrl_type o_second_card_slot
);
  import debounced_shutdown_flag_pkg::*;

  logic [CTRL_W-1:0] ctrl_q;
  logic [CTRL_W-1:0] ctrl_d;
  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;
  logic [STAT_W-1:0] stat_q;
  logic [STAT_W-1:0] stat_d;
  logic [STAT_W-1:0] mask_q;
  logic [STAT_W-1:0] mask_d;
  logic active_q;
  logic active_d;
  logic powered_q;
  logic powered_d;
  logic flag_q;
  logic flag_d;
  logic ack_q;
  logic ack_d;
  logic [DATA_W-1:0] rdat_q;
  logic [DATA_W-1:0] rdat_d;
  logic irq_q;
  logic irq_d;
  shut_kind_type kind_q;
  shut_kind_type kind_d;
  logic [1:0] stage_q;
  logic [1:0] stage_d;
  slot_ctrl_type slot_q;
  slot_ctrl_type slot_d;
  logic level;
  logic input_at_level;
  logic expired;
  logic wr;
  logic rd;
  logic wr_low;
  logic hit_ctrl;
  logic hit_count;
  logic hit_status;
  logic hit_mask;
  logic hit_slot;
  logic rearm;
  logic detect_evt;
  logic done_evt;

  assign level = ctrl_q[CTRL_LEVEL_BIT];
  // Count only while input sits at the detection level
  assign input_at_level = (i_shutdown_request_input == level) && (flag_q != level);
  assign wr = i_wb_cyc && i_wb_stb && i_wb_we && !ack_q;
  assign rd = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_q;

  sdn_debounce_counter #(
    .COUNT_W(COUNT_W)
  ) u_counter (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_tick(i_tick_32k),
    .i_active(input_at_level),
    .i_load(count_q),
    .o_expired(expired)
  );

  // Byte lane zero carries every field; upper lanes are ignored
  assign wr_low = wr && i_wb_sel[0];
  assign hit_ctrl = (i_wb_adr == ADDR_CTRL);
  assign hit_count = (i_wb_adr == ADDR_COUNT);
  assign hit_status = (i_wb_adr == ADDR_STATUS);
  assign hit_mask = (i_wb_adr == ADDR_MASK);
  assign hit_slot = (i_wb_adr == ADDR_SLOT);
  // Writing slot state with powered set releases the lines and rearms
  assign rearm = wr_low && hit_slot && i_wb_dat[SLOT_POWERED_BIT];
  assign detect_evt = expired && ctrl_q[CTRL_IRQ_EN_BIT];
  // Completion is the cycle the supply line first drops, so a read can clear it
  assign done_evt = slot_d.vcc_off && !slot_q.vcc_off;

  always_comb begin
    ctrl_d = ctrl_q;
    count_d = count_q;
    mask_d = mask_q;
    active_d = active_q;
    powered_d = powered_q;
    if (wr_low) begin
      if (hit_ctrl) begin
        ctrl_d = i_wb_dat[CTRL_W-1:0];
      end
      if (hit_count) begin
        count_d = i_wb_dat[COUNT_W-1:0];
      end
      if (hit_mask) begin
        mask_d = i_wb_dat[STAT_W-1:0];
      end
      if (hit_slot) begin
        active_d = i_wb_dat[SLOT_ACTIVE_BIT];
        powered_d = i_wb_dat[SLOT_POWERED_BIT];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_q <= CTRL_RESET;
      count_q <= COUNT_W'(COUNT_RESET);
      mask_q <= MASK_RESET;
      active_q <= 1'b0;
      powered_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      count_q <= count_d;
      mask_q <= mask_d;
      active_q <= active_d;
      powered_q <= powered_d;
    end
  end

  always_comb begin
    // One wait state: ack follows the taking edge, then drops for a cycle
    ack_d = i_wb_cyc && i_wb_stb && !ack_q;
    rdat_d = '0;
    if (rd) begin
      case (i_wb_adr)
        ADDR_CTRL: begin
          rdat_d[CTRL_W-1:0] = ctrl_q;
        end
        ADDR_COUNT: begin
          rdat_d[COUNT_W-1:0] = count_q;
        end
        ADDR_STATUS: begin
          rdat_d[STAT_W-1:0] = stat_q;
        end
        ADDR_MASK: begin
          rdat_d[STAT_W-1:0] = mask_q;
        end
        ADDR_SLOT: begin
          rdat_d[SLOT_ACTIVE_BIT] = active_q;
          rdat_d[SLOT_POWERED_BIT] = powered_q;
          rdat_d[SLOT_FLAG_BIT] = flag_q;
          rdat_d[SLOT_STAGED_BIT] = (kind_q == SHUT_STAGED);
          rdat_d[SLOT_INSTANT_BIT] = (kind_q == SHUT_INSTANT);
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  always_comb begin
    stat_d = stat_q;
    if (rd && hit_status) begin
      stat_d = '0; // Read clears; host service point
    end
    // Sets win over a read clear in the same cycle, so no event is lost
    if (detect_evt) begin
      stat_d[STAT_DETECT_BIT] = 1'b1;
    end
    if (done_evt) begin
      stat_d[STAT_SEQ_DONE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  always_comb begin
    // Level output: high while any unmasked status bit stands
    irq_d = |(stat_q & mask_q);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  always_comb begin
    flag_d = flag_q;
    kind_d = kind_q;
    stage_d = stage_q;
    slot_d = slot_q;
    // Flag follows detection level once the count expires
    if (expired) begin
      flag_d = level;
    end
    // Only slot two is sequenced; slot one has no control path here
    if (expired && kind_q == SHUT_NONE) begin
      if (active_q && i_host_card_clock_running) begin
        kind_d = SHUT_STAGED;
        stage_d = 2'd0;
      end else if (powered_q) begin
        kind_d = SHUT_INSTANT;
        stage_d = 2'd0;
        slot_d.rst_low = 1'b1;
        slot_d.clk_stop = 1'b1;
        slot_d.io_low = 1'b1;
        slot_d.vcc_off = 1'b1;
      end
    end
    case (kind_q)
      SHUT_STAGED: begin
        // Staged order: reset, clock, data, supply, one tick each
        if (i_tick_32k && stage_q != 2'd3) begin
          stage_d = stage_q + 2'd1;
        end
        case (stage_q)
          2'd0: slot_d.rst_low = 1'b1;
          2'd1: slot_d.clk_stop = 1'b1;
          2'd2: slot_d.io_low = 1'b1;
          default: slot_d.vcc_off = 1'b1;
        endcase
      end
      default: ;
    endcase
    // A rearm hands the slot back to the host; a trigger in that cycle is dropped
    if (rearm) begin
      kind_d = SHUT_NONE;
      slot_d = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flag_q <= 1'b0;
      kind_q <= SHUT_NONE;
      stage_q <= 2'd0;
      slot_q <= '0;
    end else begin
      flag_q <= flag_d;
      kind_q <= kind_d;
      stage_q <= stage_d;
      slot_q <= slot_d;
    end
  end

  assign o_wb_dat = rdat_q;
  assign o_wb_ack = ack_q;
  assign o_irq = irq_q;
  assign o_debounced_shutdown_flag = flag_q;
  assign o_second_card_slot = slot_q;
endmodule
`default_nettype wire

// file: sim/sdn_host_clk_model.sv
`timescale 1ns/10ps
`default_nettype none
module sdn_host_clk_model (
  input wire logic i_clk,
  input wire logic i_run,
  output logic o_running
);
  // Registered so the status only moves on the design's sampling edge
  always_ff @(posedge i_clk) begin
    o_running <= i_run;
  end
endmodule
`default_nettype wire

// file: sim/debounced_shutdown_flag_checker.sv
`timescale 1ns/10ps
`default_nettype none
module debounced_shutdown_flag_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick_32k,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic o_irq,
  input wire logic o_debounced_shutdown_flag,
  input wire debounced_shutdown_flag_pkg::slot_ctrl_type o_second_card_slot
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_flag_on_tick: assert property (
    $changed(o_debounced_shutdown_flag) |-> $past(i_tick_32k, 2)) else $error("flag moved off tick");
  a_instant_whole: assert property (
    $past(o_second_card_slot) == 4'h0 && o_second_card_slot != 4'h0 |-> o_second_card_slot inside {4'h8, 4'hF})
    else $error("slot lines start wrong");
  a_staged_order: assert property (
    o_second_card_slot.io_low |-> o_second_card_slot.rst_low && o_second_card_slot.clk_stop)
    else $error("slot line order broken");
  a_staged_step: assert property (
    $rose(o_second_card_slot.clk_stop) && $past(o_second_card_slot.rst_low) |-> $past(i_tick_32k) ||
    $past(i_tick_32k, 2)) else $error("stage step off tick");
  a_irq_holds: assert property (
    $fell(o_irq) |-> $past(i_wb_cyc && i_wb_stb) || $past(i_wb_cyc && i_wb_stb, 2))
    else $error("irq dropped unserviced");
  a_ack_pulse: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack) else $error("ack not one pulse");
endmodule
bind shutdown_input_debounce debounced_shutdown_flag_checker u_debounced_shutdown_flag_checker (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_tick_32k(i_tick_32k), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_irq(o_irq),
  .o_debounced_shutdown_flag(o_debounced_shutdown_flag), .o_second_card_slot(o_second_card_slot));
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import debounced_shutdown_flag_pkg::*;
  logic clk = 0, rst_n = 0, tick = 0, sdn = 0, run = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, rd;
  logic ack, irq, flag, hc;
  slot_ctrl_type slot;
  int n_fail = 0, cmp_count = 0, cyc_n = 0, n;
  shutdown_input_debounce u_shutdown_input_debounce (.i_clk(clk), .i_rst_n(rst_n), .i_tick_32k(tick),
    .i_shutdown_request_input(sdn), .i_host_card_clock_running(hc), .i_wb_adr(adr), .i_wb_dat(wd),
    .i_wb_sel(4'hF), .i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(rdat), .o_wb_ack(ack),
    .o_irq(irq), .o_debounced_shutdown_flag(flag), .o_second_card_slot(slot));
  sdn_host_clk_model u_sdn_host_clk_model (.i_clk(clk), .i_run(run), .o_running(hc));
  initial forever #12.5 clk = ~clk;
  // Tick every 8 clocks keeps runs short
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    tick <= (cyc_n % 8) == 7;
    if (cyc_n == 5000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (ack !== 1'h1);
    rd = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask
  task automatic wt(input int k, input int c);
    repeat (k) @(posedge clk iff tick);
    repeat (c) @(posedge clk);
  endtask
  initial begin
    void'($urandom(32'hA38E));
    n = 2 + $urandom % 4;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    bus(1'h0, ADDR_COUNT, 32'h0);
    chk(rd[3:0], 4'h4);
    bus(1'h0, ADDR_SLOT, 32'h0);
    chk(rd[3:0], 4'h0);
    bus(1'h1, 8'h14, 32'hFF);
    bus(1'h0, 8'h14, 32'h0);
    chk(rd[3:0], 4'h0);
    bus(1'h1, ADDR_COUNT, 32'(n));
    bus(1'h1, ADDR_CTRL, 32'h3);
    bus(1'h1, ADDR_MASK, 32'h1);
    bus(1'h1, ADDR_SLOT, 32'h2);
    wt(1, 0);
    sdn <= 1'h1;
    wt(n - 1, 2);
    chk(4'(flag), 4'h0);
    wt(1, 4);
    chk(4'(flag), 4'h1);
    chk(slot, 4'hF);
    chk(4'(irq), 4'h1);
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk(rd[3:0] & 4'h1, 4'h1);
    wt(0, 3);
    chk(4'(irq), 4'h0);
    run <= 1'h1;
    bus(1'h1, ADDR_SLOT, 32'h3);
    bus(1'h1, ADDR_CTRL, 32'h2);
    wt(1, 0);
    sdn <= 1'h0;
    wt(n - 1, 2);
    chk(4'(flag), 4'h1);
    wt(1, 4);
    chk(4'(flag), 4'h0);
    chk(slot, 4'h8);
    chk(4'(irq), 4'h1);
    wt(3, 3);
    chk(slot, 4'hF);
    bus(1'h0, ADDR_SLOT, 32'h0);
    chk(rd[3:0], 4'hB);
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk(rd[3:0], 4'h3);
    // Mid-run reset: flag, irq, slot lines and count must come back to their idle values
    rst_n <= 1'h0;
    wt(0, 3);
    rst_n <= 1'h1;
    wt(0, 1);
    chk(4'(flag), 4'h0);
    chk(4'(irq), 4'h0);
    chk(slot, 4'h0);
    bus(1'h0, ADDR_COUNT, 32'h0);
    chk(rd[3:0], 4'h4);
    close_out();
  end
endmodule
`default_nettype wire
